// *** board_model.sv ***
// board side of the block: reset button with pull-up and eight wake keys
// assumes the bench calls set_reset and set_keys from its own sequence
`timescale 1ns/1ps
`default_nettype none
module board_model
    import stop_reset_pkg::*;
(
    input  wire logic    clk,
    output var  logic    reset_pin_n,
    output var  wake_pins_type wake_pins
);
    // ------------------------------------------------------------
    // idle lines sit at the pull-up level
    // ------------------------------------------------------------
    initial begin
        reset_pin_n = 1'b1;
        wake_pins   = 8'hff;
    end

    // button level, changed right after an edge; caller times the hold
    task automatic set_reset(input logic lvl);
        @(posedge clk);
        reset_pin_n <= lvl;
    endtask : set_reset

    // key levels, low means pressed, released keys float high
    task automatic set_keys(input logic [7:0] lvl);
        @(posedge clk);
        wake_pins <= lvl;
    endtask : set_keys
endmodule : board_model
`default_nettype wire

// *** stop_reset_ctrl.sv ***
// stop-mode, wake-up wait and reset-source control for the core
// assumes synchronous pin inputs and a core that obeys core_run
`timescale 1ns/1ps
`default_nettype none
module stop_reset_ctrl
    import stop_reset_pkg::*;
#(
    parameter int TICK_CYCLES  = TICK_CYC,
    parameter int FILT_CYCLES  = FILT_CYC,
    parameter int WDT_CYCLES   = WDT_CYC,
    parameter int WATCHDOG_RESET_OUT_CYCLES = WATCHDOG_RESET_OUT_CYC
) (
    input  wire logic          clk,
    input  wire logic          rst_b,
    input  wire logic          reset_pin_n,
    input  wire logic          stop_exec,
    input  wire logic [3:0]    stop_operand,
    input  wire wake_pins_type wake_pins,
    input  wire logic [2:0]    stack_ptr,
    input  wire bus_req_type   bus_req,
    output var  logic [15:0]   bus_rdata,
    output var  logic          osc_enable,
    output var  logic          core_run,
    output var  logic          pc_clear,
    output var  logic          port_init,
    output var  logic          watchdog_reset_out_n,
    output var  logic          timer_irq_flag
);

    // ------------------------------------------------------------
    // parameter checks
    // ------------------------------------------------------------
    if (TICK_CYCLES < 1 || FILT_CYCLES < 1 || WDT_CYCLES < 2 ||
        WATCHDOG_RESET_OUT_CYCLES < 1) begin : g_bad_param
        $error("stop_reset_ctrl: cycle counts must be positive");
    end

    // ------------------------------------------------------------
    // state
    // ------------------------------------------------------------
    mode_type    mode_reg;
    logic [31:0] low_cnt_reg;
    logic [31:0] presc_reg;
    logic [7:0]  tcount_reg;
    logic [7:0]  timer_modulo_value;
    logic [31:0] wdt_cnt_reg;
    logic [31:0] watchdog_reset_out_cnt_reg;
    logic [15:0] data_buffer_word;
    logic [7:0]  carrier_high_modulo;
    logic [7:0]  carrier_low_modulo;
    logic [3:0]  window_reg;
    logic        kept_reg;
    logic [15:0] rd_data_reg;

    logic all_high, any_low, stop_ok, reset_hit, tick, match_tick;
    logic sp_fault, wdt_fault, fault, wake, in_reset, wr_ctrl, wr_stat;

    function automatic logic hit(input bus_req_type r,
                                 input logic [3:0] a);
        hit = r.wr && (r.addr == a);
    endfunction : hit

    // ------------------------------------------------------------
    // decoding of events
    // ------------------------------------------------------------
    assign all_high  = &{wake_pins.port_a, wake_pins.port_b};
    assign any_low   = !all_high;
    assign stop_ok   = stop_exec && (mode_reg == ST_RUN) &&
                       (stop_operand == STOP_OPERAND) && all_high;
    assign wake      = (mode_reg == ST_STOP) && any_low;
    assign reset_hit = !reset_pin_n &&
                       (low_cnt_reg == 32'(FILT_CYCLES));
    assign in_reset  = (mode_reg == ST_RESET);
    assign tick      = osc_enable && (presc_reg == 32'(TICK_CYCLES - 1));
    assign match_tick = tick && (tcount_reg == timer_modulo_value);
    assign sp_fault  = (mode_reg == ST_RUN) &&
                       (stack_ptr >= SP_FAULT_MIN);
    assign wdt_fault = (mode_reg == ST_RUN) &&
                       (wdt_cnt_reg == 32'(WDT_CYCLES - 1));
    assign fault     = !reset_hit && (sp_fault || wdt_fault);
    assign wr_ctrl   = hit(bus_req, ADDR_CTRL);
    assign wr_stat   = hit(bus_req, ADDR_STATUS);

    // oscillator and core controls
    assign osc_enable = (mode_reg == ST_WAIT) || (mode_reg == ST_RUN);
    assign core_run   = (mode_reg == ST_RUN);
    assign pc_clear   = in_reset || fault;
    assign port_init  = in_reset;

    // ------------------------------------------------------------
    // reset-pin low filter
    // ------------------------------------------------------------
    always_ff @(posedge clk or negedge rst_b) begin
        if (!rst_b) begin
            low_cnt_reg <= '0;
        end else if (reset_pin_n) begin
            low_cnt_reg <= '0;
        end else if (low_cnt_reg <= 32'(FILT_CYCLES)) begin
            low_cnt_reg <= low_cnt_reg + 32'd1;
        end
    end

    // ------------------------------------------------------------
    // mode sequencer
    // ------------------------------------------------------------
    always_ff @(posedge clk or negedge rst_b) begin
        if (!rst_b) begin
            mode_reg <= ST_RESET;
        end else if (reset_hit) begin
            mode_reg <= ST_RESET;
        end else begin
            case (mode_reg)
                ST_RESET: if (reset_pin_n) begin
                    mode_reg <= ST_WAIT;
                end
                ST_WAIT: if (match_tick) begin
                    mode_reg <= ST_RUN;
                end
                ST_RUN: if (stop_ok && !fault) begin
                    mode_reg <= ST_STOP;
                end
                ST_STOP: if (wake) begin
                    mode_reg <= ST_WAIT;
                end
                default: mode_reg <= ST_RESET;
            endcase
        end
    end

    // kept flag: last reset arrived while in standby
    always_ff @(posedge clk or negedge rst_b) begin
        if (!rst_b) begin
            kept_reg <= 1'b0;
        end else if (reset_hit && !in_reset) begin
            kept_reg <= (mode_reg == ST_STOP) ||
                        (mode_reg == ST_WAIT);
        end
    end

    // ------------------------------------------------------------
    // modulo timer: prescaler, count, flag
    // ------------------------------------------------------------
    always_ff @(posedge clk or negedge rst_b) begin
        if (!rst_b) begin
            presc_reg  <= '0;
            tcount_reg <= TCOUNT_RST;
        end else if (in_reset || wake) begin
            presc_reg  <= '0;
            tcount_reg <= TCOUNT_RST;
        end else if (tick) begin
            presc_reg  <= '0;
            tcount_reg <= match_tick ? TCOUNT_RST
                                     : tcount_reg + 8'h01;
        end else if (osc_enable) begin
            presc_reg  <= presc_reg + 32'd1;
        end
    end

    // flag: set wins over a software clear
    always_ff @(posedge clk or negedge rst_b) begin
        if (!rst_b) begin
            timer_irq_flag <= 1'b0;
        end else if (in_reset || wake) begin
            timer_irq_flag <= 1'b0;
        end else if (match_tick) begin
            timer_irq_flag <= 1'b1;
        end else if (wr_stat && bus_req.wdata[STAT_IRQ]) begin
            timer_irq_flag <= 1'b0;
        end
    end

    // ------------------------------------------------------------
    // watchdog counter and pin driver
    // ------------------------------------------------------------
    always_ff @(posedge clk or negedge rst_b) begin
        if (!rst_b) begin
            wdt_cnt_reg <= '0;
        end else if (in_reset || fault ||
                     (wr_ctrl && bus_req.wdata[CTRL_WDT_CLR])) begin
            wdt_cnt_reg <= '0;
        end else if (osc_enable) begin
            wdt_cnt_reg <= wdt_cnt_reg + 32'd1;  // held, not cleared, in stop
        end
    end

    always_ff @(posedge clk or negedge rst_b) begin
        if (!rst_b) begin
            watchdog_reset_out_cnt_reg        <= '0;
            watchdog_reset_out_n <= 1'b1;
        end else if (fault) begin
            watchdog_reset_out_cnt_reg        <= 32'(WATCHDOG_RESET_OUT_CYCLES - 1);
            watchdog_reset_out_n <= 1'b0;
        end else if (watchdog_reset_out_cnt_reg != '0) begin
            watchdog_reset_out_cnt_reg        <= watchdog_reset_out_cnt_reg - 32'd1;
        end else begin
            watchdog_reset_out_n <= 1'b1;
        end
    end

    // ------------------------------------------------------------
    // software registers
    // ------------------------------------------------------------
    always_ff @(posedge clk or negedge rst_b) begin
        if (!rst_b) begin
            timer_modulo_value <= TMOD_RST;
            data_buffer_word   <= DBUF_RST;
        end else if (in_reset) begin
            timer_modulo_value <= TMOD_RST;
            data_buffer_word   <= DBUF_RST;
        end else begin
            if (hit(bus_req, ADDR_TMOD)) begin
                timer_modulo_value <= bus_req.wdata[7:0];
            end
            if (hit(bus_req, ADDR_DBUF)) begin
                data_buffer_word <= bus_req.wdata;
            end
        end
    end

    // retained state: untouched by the reset pin
    always_ff @(posedge clk or negedge rst_b) begin
        if (!rst_b) begin
            carrier_high_modulo <= 8'h00;
            carrier_low_modulo  <= 8'h00;
            window_reg          <= 4'h0;
        end else if (!in_reset) begin
            if (hit(bus_req, ADDR_CARR_H)) begin
                carrier_high_modulo <= bus_req.wdata[7:0];
            end
            if (hit(bus_req, ADDR_CARR_L)) begin
                carrier_low_modulo <= bus_req.wdata[7:0];
            end
            if (hit(bus_req, ADDR_WINDOW)) begin
                window_reg <= bus_req.wdata[3:0];
            end
        end
    end

    // read data, valid only in the cycle after the read strobe
    always_comb begin
        case (bus_req.addr)
            ADDR_TMOD:   rd_data_reg = {8'h00, timer_modulo_value};
            ADDR_TCOUNT: rd_data_reg = {8'h00, tcount_reg};
            ADDR_STATUS: rd_data_reg = {12'h000, mode_reg, kept_reg,
                                        timer_irq_flag};
            ADDR_DBUF:   rd_data_reg = data_buffer_word;
            ADDR_CARR_H: rd_data_reg = {8'h00, carrier_high_modulo};
            ADDR_CARR_L: rd_data_reg = {8'h00, carrier_low_modulo};
            ADDR_WINDOW: rd_data_reg = {12'h000, window_reg};
            default:     rd_data_reg = 16'h0000;
        endcase
    end

    always_ff @(posedge clk or negedge rst_b) begin
        if (!rst_b) begin
            bus_rdata  <= 16'h0000;
        end else begin
            bus_rdata  <= bus_req.rd ? rd_data_reg : 16'h0000;
        end
    end

    // ------------------------------------------------------------
    // checks
    // ------------------------------------------------------------
    logic [8:0] wait_ticks_reg;  // ticks seen in the current wait
    always_ff @(posedge clk or negedge rst_b) begin
        if (!rst_b) begin
            wait_ticks_reg <= '0;
        end else if (mode_reg != ST_WAIT) begin
            wait_ticks_reg <= '0;
        end else if (tick) begin
            wait_ticks_reg <= wait_ticks_reg + 9'h001;
        end
    end

    property p_stop_osc;
        @(posedge clk) disable iff (!rst_b)
        mode_reg == ST_STOP && !wake && !reset_hit |=>
            !osc_enable && !core_run && mode_reg == ST_STOP;
    endproperty
    a_stop_osc: assert property (p_stop_osc)
        else $error("oscillator or core ran in stop");

    property p_wake;
        @(posedge clk) disable iff (!rst_b)
        mode_reg == ST_STOP && any_low && !reset_hit |=> mode_reg == ST_WAIT;
    endproperty
    a_wake: assert property (p_wake)
        else $error("wake pin low did not release stop");

    property p_stop_nop;
        @(posedge clk) disable iff (!rst_b)
        stop_exec && core_run && (!all_high ||
            stop_operand != STOP_OPERAND) && !fault && !reset_hit
            |=> core_run;
    endproperty
    a_stop_nop: assert property (p_stop_nop)
        else $error("refused stop halted the core");

    property p_release;
        @(posedge clk) disable iff (!rst_b)
        wake && !reset_hit |=> !timer_irq_flag && tcount_reg == 8'h00
            && presc_reg == '0;
    endproperty
    a_release: assert property (p_release)
        else $error("release left timer or flag uncleared");

    property p_wait_len;
        @(posedge clk) disable iff (!rst_b)
        mode_reg == ST_WAIT && match_tick && !reset_hit |->
            wait_ticks_reg == {1'b0, timer_modulo_value} ##1 core_run;
    endproperty
    a_wait_len: assert property (p_wait_len)
        else $error("wake wait was not modulo plus one ticks");

    property p_reset_filter;
        @(posedge clk) disable iff (!rst_b)
        $rose(in_reset) |-> $past(!reset_pin_n, 1) &&
            $past(low_cnt_reg) == 32'(FILT_CYCLES);
    endproperty
    a_reset_filter: assert property (p_reset_filter)
        else $error("reset taken before the filter time");

    property p_reset_state;
        @(posedge clk) disable iff (!rst_b)
        in_reset ##1 !in_reset |-> mode_reg == ST_WAIT &&
            timer_modulo_value == TMOD_RST && tcount_reg == TCOUNT_RST
            && wdt_cnt_reg == '0 && data_buffer_word == DBUF_RST;
    endproperty
    a_reset_state: assert property (p_reset_state)
        else $error("state after reset is wrong");

    property p_sp_fault;
        @(posedge clk) disable iff (!rst_b)
        sp_fault && !reset_hit |-> pc_clear ##1
            (!watchdog_reset_out_n && !$past(watchdog_reset_out_n, 2)
             || !watchdog_reset_out_n);
    endproperty
    a_sp_fault: assert property (p_sp_fault)
        else $error("stack fault did not pull watchdog pin");

    property p_wdt_fault;
        @(posedge clk) disable iff (!rst_b)
        wdt_fault && !reset_hit |-> pc_clear ##1
            !watchdog_reset_out_n [*2];
    endproperty
    a_wdt_fault: assert property (p_wdt_fault)
        else $error("watchdog expiry did not pull watchdog pin");

    c_stop_wake: cover property (@(posedge clk) disable iff (!rst_b)
        mode_reg == ST_STOP ##1 mode_reg == ST_WAIT ##[1:1000] core_run);
    c_reset_in_stop: cover property (@(posedge clk) disable iff (!rst_b)
        mode_reg == ST_STOP ##1 in_reset);
    c_wdt: cover property (@(posedge clk) disable iff (!rst_b)
        wdt_fault);

endmodule : stop_reset_ctrl
`default_nettype wire

// *** stop_reset_pkg.sv ***
// constants, types and timing figures for the stop/reset controller
// assumes a 200 MHz system clock and a 16-bit register port
package stop_reset_pkg;

    // ------------------------------------------------------------
    // timing, in microseconds, and the clock rate
    // ------------------------------------------------------------
    localparam int CLK_MHZ  = 200;
    localparam int TICK_US  = 64;      // one modulo-timer tick
    localparam int FILT_US  = 50;      // least reset-pin low time
    localparam int WDT_US   = 340000;  // watchdog expiry period
    localparam int WATCHDOG_RESET_OUT_US = 60;      // watchdog pin low time
    localparam int TICK_CYC  = TICK_US * CLK_MHZ;
    localparam int FILT_CYC  = FILT_US * CLK_MHZ;
    localparam int WDT_CYC   = WDT_US * CLK_MHZ;
    localparam int WATCHDOG_RESET_OUT_CYC = WATCHDOG_RESET_OUT_US * CLK_MHZ;

    // ------------------------------------------------------------
    // register map and reset values
    // ------------------------------------------------------------
    localparam logic [3:0] ADDR_TMOD   = 4'h0;
    localparam logic [3:0] ADDR_TCOUNT = 4'h1;
    localparam logic [3:0] ADDR_CTRL   = 4'h2;
    localparam logic [3:0] ADDR_STATUS = 4'h3;
    localparam logic [3:0] ADDR_DBUF   = 4'h4;
    localparam logic [3:0] ADDR_CARR_H = 4'h5;
    localparam logic [3:0] ADDR_CARR_L = 4'h6;
    localparam logic [3:0] ADDR_WINDOW = 4'h7;
    localparam int CTRL_WDT_CLR = 0;   // watchdog_clear_bit
    localparam int STAT_IRQ     = 0;   // timer_irq_flag, write 1 clears
    localparam int STAT_KEPT    = 1;   // last reset came in standby
    localparam logic [7:0]  TMOD_RST  = 8'hff;
    localparam logic [7:0]  TCOUNT_RST = 8'h00;
    localparam logic [15:0] DBUF_RST  = 16'h0320;
    localparam logic [3:0]  STOP_OPERAND = 4'h8;
    localparam logic [2:0]  SP_FAULT_MIN = 3'h6;

    // ------------------------------------------------------------
    // types
    // ------------------------------------------------------------
    typedef enum logic [1:0] {
        ST_RESET, ST_WAIT, ST_RUN, ST_STOP
    } mode_type;

    typedef struct packed {
        logic [3:0] port_a;   // wake_port_a_pins
        logic [3:0] port_b;   // wake_port_b_pins
    } wake_pins_type;

    typedef struct packed {
        logic [3:0]  addr;
        logic [15:0] wdata;
        logic        wr;
        logic        rd;
    } bus_req_type;

endpackage : stop_reset_pkg

// *** tb.sv ***
// bench for the stop/reset controller: stop, wake, faults, reset
// assumes board_model on the reset pin and the wake keys
`timescale 1ns/1ps
`default_nettype none
module tb
    import stop_reset_pkg::*;
;
    // ------------------------------------------------------------
    // short timing, signals and instances
    // ------------------------------------------------------------
    localparam int TK = 4;
    localparam int FL = 5;
    localparam int WD = 3000;
    localparam int WO = 3;
    logic          clk = 1'b0;
    logic          rst_b;
    logic          stop_exec;
    logic [3:0]    stop_operand;
    logic [2:0]    stack_ptr;
    bus_req_type   bus_req;
    logic          reset_pin_n;
    wake_pins_type wake_pins;
    logic [15:0]   bus_rdata;
    logic          osc_enable;
    logic          core_run;
    logic          pc_clear;
    logic          port_init;
    logic          wd_n;
    logic          timer_irq_flag;
    logic          pc_seen = 1'b0;
    int            wd_low = 0;
    int            n;
    int            mismatches = 0;
    int            cmp_count = 0;

    always #2.5 clk = ~clk;

    stop_reset_ctrl #(.TICK_CYCLES(TK), .FILT_CYCLES(FL),
                      .WDT_CYCLES(WD), .WATCHDOG_RESET_OUT_CYCLES(WO)) dut (
        .clk(clk), .rst_b(rst_b), .reset_pin_n(reset_pin_n),
        .stop_exec(stop_exec), .stop_operand(stop_operand),
        .wake_pins(wake_pins), .stack_ptr(stack_ptr), .bus_req(bus_req),
        .bus_rdata(bus_rdata), .osc_enable(osc_enable),
        .core_run(core_run), .pc_clear(pc_clear), .port_init(port_init),
        .watchdog_reset_out_n(wd_n), .timer_irq_flag(timer_irq_flag));

    board_model model (.clk(clk), .reset_pin_n(reset_pin_n),
                       .wake_pins(wake_pins));

    // watchdog pin low cycles and program counter clear pulses
    always @(posedge clk) begin
        if (wd_n === 1'b0) wd_low <= wd_low + 1;
        if (pc_clear === 1'b1) pc_seen <= 1'b1;
    end

    // ------------------------------------------------------------
    // tasks
    // ------------------------------------------------------------
    task automatic summarize;
        $display("compares %0d mismatches %0d", cmp_count, mismatches);
        if (mismatches == 0 && cmp_count > 0) begin
            $display("DONE - PASS");
        end else begin
            $display("DONE - FAIL");
        end
        $finish;
    endtask : summarize

    task automatic check(input logic [15:0] s, input logic [15:0] e);
        cmp_count++;
        if (s !== e) begin
            mismatches++;
            $display("CHECK FAILED t=%0t seen %h expected %h", $time, s, e);
        end
    endtask : check

    task automatic chk1(input logic s, input logic e);
        check({15'h0, s}, {15'h0, e});
    endtask : chk1

    task automatic wr(input logic [3:0] a, input logic [15:0] v);
        @(posedge clk);
        bus_req <= '{a, v, 1'b1, 1'b0};
        @(posedge clk);
        bus_req.wr <= 1'b0;
    endtask : wr

    // read, mask and compare in the cycle after the strobe
    task automatic rdc(input logic [3:0] a, input logic [15:0] m,
                       input logic [15:0] e);
        @(posedge clk);
        bus_req <= '{a, 16'h0, 1'b0, 1'b1};
        @(posedge clk);
        bus_req.rd <= 1'b0;
        #1 check(bus_rdata & m, e);
    endtask : rdc

    task automatic stop_cmd(input logic [3:0] op);
        @(posedge clk);
        stop_exec <= 1'b1;
        stop_operand <= op;
        @(posedge clk);
        stop_exec <= 1'b0;
        #1;
    endtask : stop_cmd

    // bounded wait for core_run or the watchdog pin to reach lvl
    task automatic wait_for(input bit wd, input logic lvl, input int lim);
        n = 0;
        while ((wd ? wd_n : core_run) !== lvl) begin
            @(posedge clk);
            #1;
            n++;
            if (n > lim) begin
                mismatches++;
                $display("CHECK FAILED t=%0t wait ran out", $time);
                summarize();
            end
        end
    endtask : wait_for

    // ------------------------------------------------------------
    // test sequence
    // ------------------------------------------------------------
    initial begin
        // inputs start idle, reset held
        rst_b        <= 1'b0;
        stop_exec    <= 1'b0;
        stop_operand <= 4'h0;
        stack_ptr    <= 3'h0;
        bus_req      <= '0;
        repeat (10) @(posedge clk);
        #1 chk1(port_init & pc_clear & ~osc_enable, 1'b1);
        @(posedge clk);
        rst_b <= 1'b1;
        wait_for(1'b0, 1'b1, 1100);
        chk1(n >= 256 * TK && n <= 256 * TK + 4, 1'b1);
        rdc(ADDR_TMOD, 16'hffff, 16'h00ff);
        rdc(ADDR_DBUF, 16'hffff, 16'h0320);
        rdc(4'hf, 16'hffff, 16'h0000);
        $display("test power_on done");
        for (int op = 0; op < 16; op++) begin
            if (op != 8) begin
                stop_cmd(4'(op));
                chk1(core_run, 1'b1);
            end
        end
        for (int i = 0; i < 8; i++) begin
            model.set_keys(~(8'h01 << i));
            stop_cmd(4'h8);
            chk1(core_run, 1'b1);
            model.set_keys(8'hff);
        end
        $display("test refused_stop done");
        wr(ADDR_TMOD, 16'h0040);
        for (int i = 0; i < 8; i++) begin
            wr(ADDR_CTRL, 16'h0001);
            stop_cmd(4'h8);
            chk1(core_run | osc_enable, 1'b0);
            repeat (20) @(posedge clk);
            #1 chk1(osc_enable, 1'b0);
            model.set_keys(~(8'h01 << i));
            rdc(ADDR_TCOUNT, 16'hffff, 16'h0000);
            chk1(timer_irq_flag, 1'b0);
            wait_for(1'b0, 1'b1, 400);
            chk1(n >= 65 * TK - 3 && n <= 65 * TK + 1, 1'b1);
            chk1(timer_irq_flag, 1'b1);
            model.set_keys(8'hff);
        end
        $display("test stop_wake done");
        rdc(ADDR_STATUS, 16'h0001, 16'h0001);
        wr(ADDR_STATUS, 16'h0001);
        #1 chk1(timer_irq_flag, 1'b0);
        wr(ADDR_CTRL, 16'h0001);
        wd_low = 0;
        repeat (2) begin
            repeat (WD - 500) @(posedge clk);
            wr(ADDR_CTRL, 16'h0001);
        end
        chk1(wd_low == 0, 1'b1);
        pc_seen = 1'b0;
        wait_for(1'b1, 1'b0, WD + 20);
        chk1(n >= WD - 4 && n <= WD + 4, 1'b1);
        chk1(pc_seen, 1'b1);
        wd_low = 0;
        wait_for(1'b1, 1'b1, WO + 20);
        chk1(wd_low == WO, 1'b1);
        $display("test watchdog done");
        wr(ADDR_CTRL, 16'h0001);
        for (int sp = 5; sp <= 7; sp++) begin
            @(posedge clk);
            stack_ptr <= 3'(sp);
            #1 chk1(pc_clear, sp != 5);
            @(posedge clk);
            stack_ptr <= 3'h0;
            #1 chk1(wd_n, sp == 5);
            repeat (WO + 2) @(posedge clk);
        end
        $display("test stack_fault done");
        for (int h = FL; h <= FL + 1; h++) begin
            model.set_reset(1'b0);
            repeat (h - 1) @(posedge clk);
            model.set_reset(1'b1);
            @(posedge clk);
            #1 chk1(core_run, h == FL);
        end
        wait_for(1'b0, 1'b1, 1100);
        rdc(ADDR_STATUS, 16'h0002, 16'h0000);
        wr(ADDR_DBUF, 16'h1234);
        wr(ADDR_TMOD, 16'h0012);
        wr(ADDR_CARR_H, 16'h00a5);
        wr(ADDR_CARR_L, 16'h005a);
        wr(ADDR_WINDOW, 16'h0009);
        stop_cmd(4'h8);
        model.set_reset(1'b0);
        repeat (FL + 3) @(posedge clk);
        #1 chk1(port_init & pc_clear & ~osc_enable, 1'b1);
        rdc(ADDR_TMOD, 16'hffff, 16'h00ff);
        rdc(ADDR_TCOUNT, 16'hffff, 16'h0000);
        rdc(ADDR_DBUF, 16'hffff, 16'h0320);
        rdc(ADDR_STATUS, 16'h000e, 16'h0002);
        model.set_reset(1'b1);
        wait_for(1'b0, 1'b1, 1100);
        chk1(n >= 256 * TK && n <= 256 * TK + 4, 1'b1);
        rdc(ADDR_CARR_H, 16'hffff, 16'h00a5);
        rdc(ADDR_CARR_L, 16'hffff, 16'h005a);
        rdc(ADDR_WINDOW, 16'hffff, 16'h0009);
        $display("test reset_pin done");
        summarize();
    end
endmodule : tb
`default_nettype wire
